// ### inc/cfps_pkg.sv
// Constants and types of the charger fault-protection sequencer
package cfps_pkg;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 125000000;
  localparam int unsigned TICK_US        = 1;
  localparam int unsigned TICK_CYC       = CLK_HZ / 1000000 * TICK_US;
  localparam int unsigned TICK_CW        = 7;
  localparam logic [6:0]  TICK_LAST      = 7'(TICK_CYC - 1);

  // ----------------------------------------------------------------
  // Protection times, in microseconds
  // ----------------------------------------------------------------
  localparam int unsigned IOC_BLANK_US   = 2500;
  localparam int unsigned IOC_RETRY_US   = 1300000;
  localparam int unsigned IOC_WINDOW_US  = 90000000;
  localparam int unsigned OVP_PERSIST_US = 30000;
  localparam int unsigned LOWV_HOLD_US   = 1000;
  localparam int unsigned SS_STEP_US     = 240;

  localparam int unsigned TIMER_W        = 27;
  localparam int unsigned IOC_TRIP_LIMIT = 7;
  localparam int unsigned SHORT_LIMIT    = 7;
  localparam logic [2:0]  TRIP_LIMIT_3   = 3'h7;

  // ----------------------------------------------------------------
  // Option register fields
  // ----------------------------------------------------------------
  localparam int unsigned OPT_W          = 16;
  localparam int unsigned OPT_INHIBIT    = 0;
  localparam int unsigned OPT_IOC_LO     = 1;
  localparam int unsigned OPT_CMP_REF    = 4;
  localparam int unsigned OPT_HS_LO      = 7;
  localparam int unsigned OPT_FTRIM_EN   = 9;
  localparam int unsigned OPT_FTRIM_UP   = 10;

  // Input overcurrent threshold codes
  localparam logic [1:0]  IOC_OFF        = 2'h0;
  localparam logic [1:0]  IOC_X133       = 2'h1;
  localparam logic [1:0]  IOC_X166       = 2'h2;
  localparam logic [1:0]  IOC_X222       = 2'h3;

  // Charge peak overcurrent levels (6A, 9A, 12A)
  localparam logic [1:0]  PEAK_6A        = 2'h0;
  localparam logic [1:0]  PEAK_9A        = 2'h1;
  localparam logic [1:0]  PEAK_12A       = 2'h2;
  localparam int unsigned ICHG_W         = 7;
  localparam logic [6:0]  ICHG_9A_MIN    = 7'h30;
  localparam logic [6:0]  ICHG_12A_MIN   = 7'h60;

  // Soft-start in 64 mA steps: start at two steps (128 mA)
  localparam logic [6:0]  SS_START       = 7'h02;
  localparam logic [6:0]  SS_INC         = 7'h01;
  localparam logic [6:0]  LOWV_CAP       = 7'h08;

  // Switching frequency selection
  localparam logic [1:0]  FSW_NOMINAL    = 2'h0;
  localparam logic [1:0]  FSW_LOWER      = 2'h1;
  localparam logic [1:0]  FSW_HIGHER     = 2'h2;

  typedef enum logic [1:0] {
    CFPS_ST_OFF,
    CFPS_ST_SOFT,
    CFPS_ST_RUN,
    CFPS_ST_LATCH
  } cfps_state_t;

endpackage

// ### logic/cfps_timer.sv
// Tick-driven down counter used for the protection intervals
`timescale 1ns/1ps
module cfps_timer
  import cfps_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               tick,
  input  wire logic               load,
  input  wire logic [TIMER_W-1:0] loadValue,
  output logic                    busy,
  output logic                    done
);

  logic [TIMER_W-1:0] count_r;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      count_r <= '0;
      done    <= 1'b0;
    end
    else if (load)
    begin
      count_r <= loadValue;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (tick && count_r != '0)
      begin
        count_r <= count_r - 1'b1;
        done    <= (count_r == TIMER_W'(1));
      end
    end
  end

  assign busy = (count_r != '0);

endmodule

// ### logic/cfps_top.sv
// Fault sequencing and protection logic of the charge controller
`timescale 1ns/1ps
// Functional notes
// - Input current above threshold past 2.5 ms drops alarm low, stops charge.
// - After input trip, charging waits 1.3 s, restarts via soft-start if cleared.
// - Seven input trips within 90 s latch charging off until adapter reset.
// - Input trip counter clears when its 90 s window expires.
// - Two-bit option disables input protection or picks 1.33, 1.66, 2.22 multiple.
// - Peak overcurrent cuts high-side gate until the next switching cycle.
// - Peak threshold picked from 6, 9, 12 A by programmed charge current.
// - Battery overvoltage holds both gates off.
// - Overvoltage lasting over 30 ms fully disables the charger.
// - Discharge sink is on only while overvoltage is active.
// - Battery low stops charge 1 ms then soft-starts if enables hold.
// - While battery low, current capped and low-side off except refresh.
// - Thermal shutdown above upper, resume below lower through soft-start.
// - During thermal shutdown, regulator current limit is reduced.
// - Option bits enable frequency trim and select lower or higher rate.
// - Seven short events from the two comparators latch charger off.
// - Short latch clears only on supply undervoltage or adapter reset.
// - Low-side short threshold fixed; two-bit option sets high-side threshold.
// - Short comparators ignored during blanking after each gate turn-on.
// - Comparator output released when input above reference, else driven low.
// - Option bit picks lower or higher comparator reference.
// - Soft-start begins low, steps current up at fixed intervals to limit.
// - Input overcurrent and the inhibit option bit both inhibit charging.
module cfps_top
  import cfps_pkg::*;
#(
  parameter int unsigned IOC_BLANK_CYC  = IOC_BLANK_US,
  parameter int unsigned IOC_RETRY_CYC  = IOC_RETRY_US,
  parameter int unsigned IOC_WINDOW_CYC = IOC_WINDOW_US
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic [cfps_pkg::OPT_W-1:0]  optionReg,
  input  wire logic [cfps_pkg::ICHG_W-1:0] chargeCurrentSet,
  input  wire logic                  inputOvercurrent,
  input  wire logic                  chargePeakOvercurrent,
  input  wire logic                  batteryOvervoltage,
  input  wire logic                  batteryLowVoltage,
  input  wire logic                  thermalHigh,
  input  wire logic                  thermalLow,
  input  wire logic                  adapterDetectLow,
  input  wire logic                  supplyUndervoltage,
  input  wire logic                  cycleStart,
  input  wire logic                  gateOnBlankDone,
  input  wire logic                  highSideShort,
  input  wire logic                  lowSideShort,
  input  wire logic                  pwmHighReq,
  input  wire logic                  pwmLowReq,
  input  wire logic                  bootRefreshReq,
  input  wire logic                  comparatorAbove,
  output logic                       faultAlarm_n,
  output logic                       chargeEnable,
  output logic                       highSideGate,
  output logic                       lowSideGate,
  output logic                       dischargeSink,
  output logic                       regulatorLimitLow,
  output logic [1:0]                 inputOcThreshold,
  output logic [1:0]                 peakOcThreshold,
  output logic [1:0]                 highSideShortThr,
  output logic [1:0]                 switchFreqSel,
  output logic                       comparatorRefHigh,
  output logic                       comparatorOutOe,
  output logic [cfps_pkg::ICHG_W-1:0] chargeCurrentCmd,
  output logic                       latchedOff
);

  // ----------------------------------------------------------------
  // Time base and common clear
  // ----------------------------------------------------------------
  logic [TICK_CW-1:0] tickCnt_r;
  logic               tick;
  logic               clr;

  assign clr  = !rst_n || adapterDetectLow;
  assign tick = (tickCnt_r == TICK_LAST);

  always_ff @(posedge ref_clk)
  begin
    if (clr || tick)
      tickCnt_r <= '0;
    else
      tickCnt_r <= tickCnt_r + 1'b1;
  end

  // ----------------------------------------------------------------
  // Input overcurrent: blanking, retry, trip window
  // ----------------------------------------------------------------
  logic                ocEnabled;
  logic [11:0]         blank_r;
  logic                ocTrip;
  logic                retryBusy;
  logic                windowBusy;
  logic                windowLoad;
  logic [2:0]          tripCount_r;
  logic                ocLatch_r;

  assign ocEnabled = optionReg[OPT_IOC_LO +: 2] != IOC_OFF;
  assign ocTrip    = ocEnabled && inputOvercurrent && tick && !retryBusy
                     && (blank_r == 12'(IOC_BLANK_CYC - 1));

  always_ff @(posedge ref_clk)
  begin
    if (clr || !inputOvercurrent || !ocEnabled || retryBusy)
      blank_r <= '0;
    else if (tick && blank_r != 12'(IOC_BLANK_CYC - 1))
      blank_r <= blank_r + 1'b1;
  end

  cfps_timer u_retry
  (
    .ref_clk   (ref_clk),
    .rst_n     (!clr),
    .tick      (tick),
    .load      (ocTrip),
    .loadValue (TIMER_W'(IOC_RETRY_CYC)),
    .busy      (retryBusy),
    .done      ()
  );

  assign windowLoad = ocTrip && !windowBusy;

  cfps_timer u_window
  (
    .ref_clk   (ref_clk),
    .rst_n     (!clr),
    .tick      (tick),
    .load      (windowLoad),
    .loadValue (TIMER_W'(IOC_WINDOW_CYC)),
    .busy      (windowBusy),
    .done      ()
  );

  always_ff @(posedge ref_clk)
  begin
    if (clr)
      tripCount_r <= '0;
    else if (ocTrip)
      tripCount_r <= windowBusy ? tripCount_r + 1'b1 : 3'h1;
    else if (!windowBusy)
      tripCount_r <= '0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr)
      ocLatch_r <= 1'b0;
    else if (ocTrip && windowBusy && tripCount_r == TRIP_LIMIT_3 - 3'h1)
      ocLatch_r <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr)
      faultAlarm_n <= 1'b1;
    else
      faultAlarm_n <= !(retryBusy || ocTrip || ocLatch_r);
  end

  // ----------------------------------------------------------------
  // Short-circuit counting after gate blanking
  // ----------------------------------------------------------------
  logic       shortEvent;
  logic [2:0] shortCount_r;
  logic       shortLatch_r;

  assign shortEvent = gateOnBlankDone && (highSideShort || lowSideShort);

  always_ff @(posedge ref_clk)
  begin
    if (clr || supplyUndervoltage)
    begin
      shortCount_r <= '0;
      shortLatch_r <= 1'b0;
    end
    else if (shortEvent && !shortLatch_r)
    begin
      shortCount_r <= shortCount_r + 1'b1;
      if (shortCount_r == 3'(SHORT_LIMIT - 1))
        shortLatch_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Battery overvoltage, battery low, thermal
  // ----------------------------------------------------------------
  logic [14:0] ovpCnt_r;
  logic        ovpLatch_r;
  logic        lowvBusy;
  logic        lowvStart;
  logic        lowvSeen_r;
  logic        thermal_r;

  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      ovpCnt_r   <= '0;
      ovpLatch_r <= 1'b0;
    end
    else if (!batteryOvervoltage)
      ovpCnt_r <= '0;
    else if (tick)
    begin
      if (ovpCnt_r == 15'(OVP_PERSIST_US))
        ovpLatch_r <= 1'b1;
      else
        ovpCnt_r <= ovpCnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr)
      lowvSeen_r <= 1'b0;
    else
      lowvSeen_r <= batteryLowVoltage;
  end

  assign lowvStart = batteryLowVoltage && !lowvSeen_r;

  cfps_timer u_lowv
  (
    .ref_clk   (ref_clk),
    .rst_n     (!clr),
    .tick      (tick),
    .load      (lowvStart),
    .loadValue (TIMER_W'(LOWV_HOLD_US)),
    .busy      (lowvBusy),
    .done      ()
  );

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      thermal_r <= 1'b0;
    else if (thermalHigh)
      thermal_r <= 1'b1;
    else if (thermalLow)
      thermal_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Charge sequencing and soft-start
  // ----------------------------------------------------------------
  cfps_state_t state_r;
  logic        latch;
  logic        inhibit;
  logic [7:0]  ssCnt_r;
  logic        ssStep;

  assign latch   = ocLatch_r || shortLatch_r || ovpLatch_r;
  assign inhibit = optionReg[OPT_INHIBIT] || retryBusy || ocTrip
                   || batteryOvervoltage || lowvBusy || lowvStart
                   || thermal_r || thermalHigh;
  assign ssStep  = tick && ssCnt_r == 8'(SS_STEP_US - 1);

  always_ff @(posedge ref_clk)
  begin
    if (clr || state_r != CFPS_ST_SOFT || ssStep)
      ssCnt_r <= '0;
    else if (tick)
      ssCnt_r <= ssCnt_r + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      state_r          <= CFPS_ST_OFF;
      chargeCurrentCmd <= '0;
    end
    else if (latch)
    begin
      state_r          <= CFPS_ST_LATCH;
      chargeCurrentCmd <= '0;
    end
    else
    begin
      case (state_r)
        CFPS_ST_OFF:
        begin
          chargeCurrentCmd <= '0;
          if (!inhibit && chargeCurrentSet != '0)
          begin
            state_r          <= CFPS_ST_SOFT;
            chargeCurrentCmd <= SS_START;
          end
        end
        CFPS_ST_SOFT, CFPS_ST_RUN:
        begin
          if (inhibit)
          begin
            state_r          <= CFPS_ST_OFF;
            chargeCurrentCmd <= '0;
          end
          else if (batteryLowVoltage && chargeCurrentCmd > LOWV_CAP)
            chargeCurrentCmd <= LOWV_CAP;
          else if (chargeCurrentCmd >= chargeCurrentSet)
          begin
            state_r          <= CFPS_ST_RUN;
            chargeCurrentCmd <= chargeCurrentSet;
          end
          else if (ssStep && !(batteryLowVoltage && chargeCurrentCmd >= LOWV_CAP))
            chargeCurrentCmd <= chargeCurrentCmd + SS_INC;
        end
        default:
          state_r <= CFPS_ST_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Gate drive, sinks and option decoding
  // ----------------------------------------------------------------
  logic peakCut_r;
  logic running;

  assign running = (state_r == CFPS_ST_SOFT || state_r == CFPS_ST_RUN) && !inhibit;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      peakCut_r <= 1'b0;
    else if (chargePeakOvercurrent)
      peakCut_r <= 1'b1;
    else if (cycleStart)
      peakCut_r <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      highSideGate <= 1'b0;
      lowSideGate  <= 1'b0;
      chargeEnable <= 1'b0;
      latchedOff   <= 1'b0;
    end
    else
    begin
      chargeEnable <= running;
      latchedOff   <= latch || state_r == CFPS_ST_LATCH;
      highSideGate <= running && pwmHighReq && !batteryOvervoltage
                      && !chargePeakOvercurrent
                      && (!peakCut_r || cycleStart);
      lowSideGate  <= running && !batteryOvervoltage
                      && (batteryLowVoltage ? bootRefreshReq : pwmLowReq);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      dischargeSink     <= 1'b0;
      regulatorLimitLow <= 1'b0;
      comparatorOutOe   <= 1'b0;
      comparatorRefHigh <= 1'b0;
      inputOcThreshold  <= IOC_OFF;
      highSideShortThr  <= '0;
      peakOcThreshold   <= PEAK_6A;
      switchFreqSel     <= FSW_NOMINAL;
    end
    else
    begin
      dischargeSink     <= batteryOvervoltage;
      regulatorLimitLow <= thermal_r || thermalHigh;
      comparatorOutOe   <= !comparatorAbove;
      comparatorRefHigh <= optionReg[OPT_CMP_REF];
      inputOcThreshold  <= optionReg[OPT_IOC_LO +: 2];
      highSideShortThr  <= optionReg[OPT_HS_LO +: 2];
      if (chargeCurrentSet >= ICHG_12A_MIN)
        peakOcThreshold <= PEAK_12A;
      else if (chargeCurrentSet >= ICHG_9A_MIN)
        peakOcThreshold <= PEAK_9A;
      else
        peakOcThreshold <= PEAK_6A;
      if (!optionReg[OPT_FTRIM_EN])
        switchFreqSel <= FSW_NOMINAL;
      else if (optionReg[OPT_FTRIM_UP])
        switchFreqSel <= FSW_HIGHER;
      else
        switchFreqSel <= FSW_LOWER;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sink_follows_ovp_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 dischargeSink == $past(batteryOvervoltage))
    else $error("discharge sink does not follow overvoltage");
  gates_off_ovp_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    batteryOvervoltage |=> !highSideGate && !lowSideGate)
    else $error("gate on during overvoltage");
  alarm_on_trip_a: assert property (@(posedge ref_clk) disable iff (clr)
    ocTrip |=> !faultAlarm_n)
    else $error("alarm not driven on input trip");
  trip_stops_charge_a: assert property (@(posedge ref_clk) disable iff (clr)
    ocTrip |=> ##1 !chargeEnable [*4])
    else $error("charge not held off after trip");
  latch_holds_a: assert property (@(posedge ref_clk) disable iff (clr)
    (state_r == CFPS_ST_LATCH) |=> !chargeEnable)
    else $error("charge resumed while latched");
  peak_cut_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    chargePeakOvercurrent && !cycleStart |=> !highSideGate)
    else $error("high side on after peak overcurrent");
  thermal_reg_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    thermalHigh |=> regulatorLimitLow && !chargeEnable)
    else $error("thermal shutdown not applied");
  short_latch_a: assert property (@(posedge ref_clk) disable iff (clr || supplyUndervoltage)
    shortLatch_r |=> ##1 latchedOff)
    else $error("short latch not reported");
  cmp_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comparatorAbove |=> !comparatorOutOe)
    else $error("comparator output driven while above");

  trip_seen_c: cover property (@(posedge ref_clk) disable iff (clr) ocTrip);
  oc_latch_c: cover property (@(posedge ref_clk) disable iff (clr) $rose(ocLatch_r));
  soft_done_c: cover property (@(posedge ref_clk) disable iff (clr)
    state_r == CFPS_ST_SOFT ##1 state_r == CFPS_ST_RUN);

endmodule

// ### tb/cfps_stage_model.sv
// Behavioural power stage: PWM timing, gate blanking and short sensing
`timescale 1ns/1ps
module cfps_stage_model
#(
  parameter int unsigned PERIOD = 16,
  parameter int unsigned BLANK  = 3
)
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic highSideGate,
  input  wire logic lowSideGate,
  input  wire logic shortInject,
  input  wire logic blankHold,
  output logic      cycleStart,
  output logic      pwmHighReq,
  output logic      pwmLowReq,
  output logic      gateOnBlankDone,
  output logic      highSideShort,
  output logic      lowSideShort
);
  logic [7:0] phase_r;
  logic [7:0] blank_r;
  logic       hsPrev_r;
  logic       lsPrev_r;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || phase_r == PERIOD - 1)
      phase_r <= 8'h00;
    else
      phase_r <= phase_r + 8'h01;
  end

  // Blanking restarts at every switch turn-on
  always_ff @(posedge ref_clk)
  begin
    hsPrev_r <= highSideGate;
    lsPrev_r <= lowSideGate;
    if (!rst_n || (highSideGate && !hsPrev_r) || (lowSideGate && !lsPrev_r))
      blank_r <= 8'h00;
    else if (blank_r != 8'hFF)
      blank_r <= blank_r + 8'h01;
  end

  assign cycleStart      = (phase_r == 8'h00);
  assign pwmHighReq      = (phase_r < PERIOD / 2);
  assign pwmLowReq       = !pwmHighReq;
  assign gateOnBlankDone = !blankHold && (blank_r >= BLANK);
  // A shorted switch only shows its drop while it is on
  assign highSideShort   = shortInject && highSideGate;
  assign lowSideShort    = shortInject && lowSideGate;
endmodule

// ### tb/tb.sv
// Self-checking testbench of the charger fault-protection sequencer
`timescale 1ns/1ps
module tb;
  import cfps_pkg::*;
  typedef struct {string name; logic [7:0] exp; int sel;} cfps_note_t;
  localparam int CMD = 0, THR = 1, LO = 2, OE = 3, RL = 4, SK = 5, LS = 6, HS = 7, CE = 8, FA = 9;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] opt = 16'h0001;
  logic [6:0] chgSet = 7'h00;
  logic iOc = 1'b0, pkOc = 1'b0, ovp = 1'b0, lowV = 1'b0, thHi = 1'b0, thLo = 1'b1;
  logic adLow = 1'b0, uv = 1'b0, cmpAbove = 1'b0, shortInject = 1'b0, blankHold = 1'b0;
  wire logic cycleStart, pwmHi, pwmLo, blankDone, hsShort, lsShort;
  wire logic fa, ce, hs, ls, sk, rl, cmpHi, oe, lo;
  wire logic [1:0] iThr, pThr, sThr, fsw;
  wire logic [6:0] cmd;
  // Open-drain output with external pull-up
  wire logic comparator_output = !oe;
  wire logic [79:0] obs = {7'h00, fa, 7'h00, ce, 7'h00, hs, 7'h00, ls, 7'h00, sk, 7'h00, rl,
    7'h00, comparator_output, 7'h00, lo, iThr, pThr, sThr, fsw, cmpHi, cmd};
  cfps_note_t notes[$];
  cfps_note_t n;
  event look;
  int errCount = 0, numChecks = 0;

  always #4 ref_clk = ~ref_clk;

  cfps_stage_model stage (.ref_clk(ref_clk), .rst_n(rst_n), .highSideGate(hs), .lowSideGate(ls),
    .shortInject(shortInject), .blankHold(blankHold), .cycleStart(cycleStart),
    .pwmHighReq(pwmHi), .pwmLowReq(pwmLo), .gateOnBlankDone(blankDone),
    .highSideShort(hsShort), .lowSideShort(lsShort));

  cfps_top #(.IOC_BLANK_CYC(10), .IOC_RETRY_CYC(20), .IOC_WINDOW_CYC(400)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .optionReg(opt), .chargeCurrentSet(chgSet), .inputOvercurrent(iOc),
    .chargePeakOvercurrent(pkOc), .batteryOvervoltage(ovp), .batteryLowVoltage(lowV),
    .thermalHigh(thHi), .thermalLow(thLo), .adapterDetectLow(adLow), .supplyUndervoltage(uv),
    .cycleStart(cycleStart), .gateOnBlankDone(blankDone), .highSideShort(hsShort),
    .lowSideShort(lsShort), .pwmHighReq(pwmHi), .pwmLowReq(pwmLo), .bootRefreshReq(1'b0),
    .comparatorAbove(cmpAbove), .faultAlarm_n(fa), .chargeEnable(ce), .highSideGate(hs),
    .lowSideGate(ls), .dischargeSink(sk), .regulatorLimitLow(rl), .inputOcThreshold(iThr),
    .peakOcThreshold(pThr), .highSideShortThr(sThr), .switchFreqSel(fsw),
    .comparatorRefHigh(cmpHi), .comparatorOutOe(oe), .chargeCurrentCmd(cmd), .latchedOff(lo));

  // ------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------
  task automatic check(logic [7:0] seen, logic [7:0] exp, string name);
    numChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (errCount == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(look)
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      check(obs[n.sel*8 +: 8], n.exp, n.name);
    end

  task automatic note(int sel, logic [7:0] exp, string name);
    notes.push_back('{name, exp, sel});
    ->look;
  endtask

  task automatic step(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic waitv(int sel, logic [7:0] v, int lim, string name);
    for (int i = 0; i < lim && obs[sel*8 +: 8] !== v; i++)
      step(1);
    note(sel, v, name);
  endtask

  initial
  begin
    #(100000 * 8);
    errCount++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic [1:0] pk [4] = '{PEAK_6A, PEAK_9A, PEAK_9A, PEAK_12A};
    logic [6:0] st [4] = '{ICHG_9A_MIN - 7'h01, ICHG_9A_MIN, ICHG_12A_MIN - 7'h01, ICHG_12A_MIN};
    r = $urandom(30);
    step(4);
    rst_n = 1'b1;
    step(1);
    note(FA, 8'h01, "alarm");
    note(LO, 8'h00, "latch");
    for (int i = 0; i < 8; i++)
    begin
      r = $urandom();
      opt = r[15:0] | 16'h0001;
      chgSet = st[i % 4];
      cmpAbove = r[16];
      step(2);
      note(THR, {opt[2:1], pk[i % 4], opt[8:7],
        opt[9] ? (opt[10] ? FSW_HIGHER : FSW_LOWER) : FSW_NOMINAL}, "thr");
      note(CMD, {opt[4], 7'h00}, "ref");
      note(OE, {7'h00, cmpAbove}, "cmp");
      note(CE, 8'h00, "inhibit");
    end
    opt = 16'h0000;
    chgSet = 7'h05;
    waitv(CE, 8'h01, 100, "enable");
    note(CMD, 8'h02, "soft");
    iOc = 1'b1;
    step(SS_STEP_US * TICK_CYC - 130);
    note(FA, 8'h01, "alarm");
    note(CMD, 8'h02, "soft");
    iOc = 1'b0;
    step(260);
    note(CMD, 8'h03, "soft");
    waitv(HS, 8'h01, 40, "hs");
    pkOc = 1'b1;
    step(1);
    pkOc = 1'b0;
    while (!cycleStart)
    begin
      note(HS, 8'h00, "peak");
      step(1);
    end
    waitv(HS, 8'h01, 4, "peak");
    ovp = 1'b1;
    repeat (20)
    begin
      step(1);
      note(SK, 8'h01, "sink");
      note(HS, 8'h00, "ovp hs");
      note(LS, 8'h00, "ovp ls");
    end
    ovp = 1'b0;
    step(2);
    note(SK, 8'h00, "sink");
    thHi = 1'b1;
    thLo = 1'b0;
    step(3);
    note(CE, 8'h00, "thermal");
    thHi = 1'b0;
    step(50);
    note(RL, 8'h01, "internal_regulator");
    note(CE, 8'h00, "thermal");
    thLo = 1'b1;
    waitv(CE, 8'h01, 100, "thermal");
    note(RL, 8'h00, "internal_regulator");
    note(CMD, 8'h02, "soft");
    blankHold = 1'b1;
    shortInject = 1'b1;
    step(200);
    note(LO, 8'h00, "blank");
    shortInject = 1'b0;
    blankHold = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      waitv(CE, 8'h01, 200, "restart");
      shortInject = 1'b1;
      waitv(LO, 8'h01, 200, "short");
      shortInject = 1'b0;
      step(500);
      note(CE, 8'h00, "latched");
      note(LO, 8'h01, "latched");
      uv = (k == 0);
      adLow = (k == 1);
      step(2);
      uv = 1'b0;
      adLow = 1'b0;
      step(2);
      note(LO, 8'h00, "clear");
    end
    opt = 16'h0004;
    for (int t = 0; t < 7; t++)
    begin
      iOc = 1'b1;
      waitv(FA, 8'h00, 1500, "trip");
      note(CE, 8'h00, "trip");
      iOc = 1'b0;
      if (t < 6)
        waitv(CE, 8'h01, 3000, "retry");
    end
    step(2);
    note(LO, 8'h01, "oc latch");
    step(3000);
    note(FA, 8'h00, "oc latch");
    note(CE, 8'h00, "oc latch");
    adLow = 1'b1;
    step(2);
    adLow = 1'b0;
    waitv(CE, 8'h01, 200, "restart");
    lowV = 1'b1;
    step(3);
    note(CE, 8'h00, "lowbat");
    note(LS, 8'h00, "lowbat ls");
    step(1);
    give_verdict();
  end
endmodule
